//--- src/udc_core.sv
// up/down pulse counter core with APB register file
//
// Operation
// - upper limit is max signed 32-bit
// - lower limit is min signed 32-bit
// - continuous: up past upper wraps low
// - continuous: down past lower wraps high
// - continuous counting starts from load value
// - direct load immediate; prepared load on events
// - no main direction: either limit loads prepared
// - up reaches high limit, down reaches zero
// - gate start loads prepared; resume keeps count
// - sync and latch-retrigger load prepared value
// - main direction sets limits and reset states
// - none/up direction: values reset to zero
// - down direction: values reset to high limit
// - cycle request accepted, answered same cycle
// - snapshot count, latch, status per cycle
// - only pre-sample events appear this cycle
// - aux input has four functions
// - outputs: none, ge, le, pulse; window on first output only
// - hysteresis and pulse duration on outputs
// - runtime updates need no reassignment
// - three counting modes
// - internal gate is software AND hardware when aux is the gate, software otherwise, and held closed after a once-only stop
// - software gate opens on rising edge only
`timescale 1ns/1ps
module udc_core
  import udc_pkg::*;
#(
  parameter int PW_W  = 16,
  parameter int HYS_W = 8
) (
  // clock and reset
  input  wire logic            core_clk,
  input  wire logic            sys_rst,
  // encoder and auxiliary pins
  input  wire udc_pkg::udc_pulse_type pulse_in,
  input  wire logic            aux_input,
  input  wire logic            cycle_sample,
  // digital outputs
  output logic                 first_output,
  output logic                 second_output,
  // register bus
  input  wire udc_pkg::udc_apb_req_type apb_req,
  output udc_pkg::udc_apb_rsp_type      apb_rsp
);
  import udc_pkg::*;

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  logic               software_gate_bit_r;
  logic               software_gate_bit_open_r;
  logic               hardware_gate_r;
  logic               aux_prev_r;
  logic               gate_prev_r;
  logic               once_stop_r;
  udc_mode_type       mode_r;
  udc_dir_type        dir_r;
  udc_aux_type        aux_fn_r;
  logic               cancel_r;
  logic        [31:0] hi_limit_r;
  logic signed [31:0] count_r;
  logic signed [31:0] prepared_load_value_r;
  logic signed [31:0] compare_value_one_r;
  logic signed [31:0] compare_value_two_r;
  logic signed [31:0] latch_r;
  logic        [31:0] output_behaviour_params_r;
  logic signed [31:0] snap_count_r;
  logic signed [31:0] snap_latch_r;
  logic        [31:0] snap_status_r;
  logic               out1_r;
  logic               out2_r;
  logic [PW_W-1:0]    pw1_r;
  logic [PW_W-1:0]    pw2_r;
  logic               dir_up_r;
  logic        [31:0] prdata_r;

  // ------------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------------
  logic wr_en;
  logic rd_en;
  logic wr_ctrl;
  logic wr_apply;
  logic wr_direct;
  assign wr_en     = apb_req.psel && apb_req.penable && apb_req.pwrite;
  assign rd_en     = apb_req.psel && !apb_req.penable && !apb_req.pwrite;
  assign wr_ctrl   = wr_en && (apb_req.paddr == UDC_OFS_CTRL);
  assign wr_apply  = wr_ctrl && apb_req.pwdata[UDC_CTRL_APPLY];
  assign wr_direct = wr_en && (apb_req.paddr == UDC_OFS_DIRECT);

  // ------------------------------------------------------------------
  // gates and events
  // ------------------------------------------------------------------
  logic aux_rise;
  logic aux_fall;
  logic gate_int;
  logic gate_start;
  logic load_evt;
  logic latch_evt;
  logic sync_evt;
  logic step;
  logic at_hi;
  logic at_lo;
  logic limit_hit;
  logic signed [31:0] reset_val;
  assign aux_rise  = aux_input && !aux_prev_r;
  assign aux_fall  = !aux_input && aux_prev_r;
  // internal gate; hardware gate counts only when assigned
  assign gate_int  = software_gate_bit_open_r && (hardware_gate_r || aux_fn_r != UDC_AUX_GATE)
                     && !once_stop_r;
  assign gate_start = gate_int && !gate_prev_r;
  assign latch_evt = (aux_fn_r == UDC_AUX_LATCH) && aux_rise;
  assign sync_evt  = (aux_fn_r == UDC_AUX_SYNC) && aux_rise;
  assign step      = gate_int && pulse_in.count_pulse;
  // direction of a pulse is taken straight from the encoder side
  assign at_hi = pulse_in.count_up &&
                 (count_r == $signed((dir_r == UDC_DIR_UP) ? hi_limit_r : UDC_LIMIT_HI));
  assign at_lo = !pulse_in.count_up &&
                 (count_r == $signed((dir_r == UDC_DIR_DOWN) ? UDC_ZERO : UDC_LIMIT_LO));
  always_comb begin
    unique case (dir_r)
      UDC_DIR_UP:   limit_hit = at_hi;
      UDC_DIR_DOWN: limit_hit = at_lo;
      default:      limit_hit = at_hi || at_lo;
    endcase
  end
  // a canceling gate restarts from the load value; interrupting continues
  assign load_evt = (gate_start && cancel_r) || sync_evt || latch_evt;
  // main direction picks reset states and limits, never the pulse direction
  assign reset_val = (dir_r == UDC_DIR_DOWN) ? $signed(hi_limit_r) : $signed(UDC_ZERO);

  // ------------------------------------------------------------------
  // configuration registers
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      mode_r   <= UDC_MODE_CONT;
      dir_r    <= UDC_DIR_NONE;
      aux_fn_r <= UDC_AUX_INPUT;
      cancel_r <= 1'b1;
      hi_limit_r <= UDC_LIMIT_HI;
    end else if (wr_en && apb_req.paddr == UDC_OFS_CFG) begin
      mode_r   <= udc_mode_type'(apb_req.pwdata[UDC_CFG_MODE_LO +: 2]);
      dir_r    <= udc_dir_type'(apb_req.pwdata[UDC_CFG_DIR_LO +: 2]);
      aux_fn_r <= udc_aux_type'(apb_req.pwdata[UDC_CFG_AUX_LO +: 2]);
      cancel_r <= apb_req.pwdata[UDC_CFG_CANCEL];
    end else if (wr_en && apb_req.paddr == UDC_OFS_HILIM) begin
      hi_limit_r <= apb_req.pwdata;
    end
  end

  // ------------------------------------------------------------------
  // software and hardware gates
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      software_gate_bit_r <= 1'b0;
      software_gate_bit_open_r      <= 1'b0;
      hardware_gate_r     <= 1'b0;
      aux_prev_r          <= 1'b0;
      gate_prev_r         <= 1'b0;
      once_stop_r         <= 1'b0;
    end else begin
      aux_prev_r  <= aux_input;
      gate_prev_r <= gate_int;
      if (wr_ctrl) begin
        software_gate_bit_r <= apb_req.pwdata[UDC_CTRL_GATE];
        if (apb_req.pwdata[UDC_CTRL_GATE] && !software_gate_bit_r) begin
          software_gate_bit_open_r <= 1'b1;
        end else if (!apb_req.pwdata[UDC_CTRL_GATE]) begin
          software_gate_bit_open_r <= 1'b0;
        end
      end
      // the hardware gate follows the aux pin edges whatever its function
      if (aux_rise) begin
        hardware_gate_r <= 1'b1;
      end else if (aux_fall) begin
        hardware_gate_r <= 1'b0;
      end
      // once-only closes the gate at a limit until the software gate reopens
      if (step && limit_hit && mode_r == UDC_MODE_ONCE) begin
        once_stop_r <= 1'b1;
      end else if (wr_ctrl && apb_req.pwdata[UDC_CTRL_GATE] && !software_gate_bit_r) begin
        once_stop_r <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // counter
  // ------------------------------------------------------------------
  logic signed [31:0] count_nxt;
  always_comb begin
    count_nxt = count_r;
    if (wr_direct) begin
      count_nxt = $signed(apb_req.pwdata);
    end else if (load_evt) begin
      count_nxt = prepared_load_value_r;
    end else if (step && limit_hit && mode_r != UDC_MODE_CONT) begin
      count_nxt = prepared_load_value_r;
    end else if (step && pulse_in.count_up) begin
      count_nxt = count_r + $signed(UDC_ONE);
    end else if (step) begin
      count_nxt = count_r - $signed(UDC_ONE);
    end
  end

  // parameter reassignment outranks every count event in the same cycle
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      count_r <= $signed(UDC_ZERO);
      dir_up_r <= 1'b1;
    end else if (wr_apply) begin
      count_r <= reset_val;
    end else begin
      count_r <= count_nxt;
      if (step) begin
        dir_up_r <= pulse_in.count_up;
      end
    end
  end

  // ------------------------------------------------------------------
  // value registers updatable while counting
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      prepared_load_value_r <= $signed(UDC_ZERO);
      compare_value_one_r   <= $signed(UDC_ZERO);
      compare_value_two_r   <= $signed(UDC_ZERO);
      latch_r               <= $signed(UDC_ZERO);
      output_behaviour_params_r <= UDC_ZERO;
    end else if (wr_apply) begin
      prepared_load_value_r <= reset_val;
      compare_value_one_r   <= reset_val;
      compare_value_two_r   <= reset_val;
      latch_r               <= reset_val;
    end else begin
      if (wr_en && apb_req.paddr == UDC_OFS_PREP) prepared_load_value_r <= apb_req.pwdata;
      if (wr_en && apb_req.paddr == UDC_OFS_CMP1) compare_value_one_r <= apb_req.pwdata;
      if (wr_en && apb_req.paddr == UDC_OFS_CMP2) compare_value_two_r <= apb_req.pwdata;
      if (wr_en && apb_req.paddr == UDC_OFS_OUTPAR) output_behaviour_params_r <= apb_req.pwdata;
      if (latch_evt) latch_r <= count_r;
    end
  end

  // ------------------------------------------------------------------
  // comparator outputs
  // ------------------------------------------------------------------
  udc_outfn_type      fn1;
  udc_outfn_type      fn2;
  logic [HYS_W-1:0]   hys;
  logic [PW_W-1:0]    pw_len;
  logic signed [31:0] hys_s;
  assign fn1    = udc_outfn_type'(output_behaviour_params_r[UDC_OP_FN1_LO +: 3]);
  assign fn2    = udc_outfn_type'(output_behaviour_params_r[UDC_OP_FN2_LO +: 3]);
  assign hys    = output_behaviour_params_r[UDC_OP_HYS_LO +: HYS_W];
  assign pw_len = output_behaviour_params_r[UDC_OP_PW_LO +: PW_W];
  assign hys_s  = $signed({{(32-HYS_W){1'b0}}, hys});

  // one output's next level; hysteresis holds the level near the threshold
  function automatic logic out_next(input udc_outfn_type fn, input logic cur,
                                    input logic signed [31:0] cnt,
                                    input logic signed [31:0] c1,
                                    input logic signed [31:0] c2,
                                    input logic signed [31:0] h,
                                    input logic pulse_active);
    logic res;
    res = 1'b0;
    unique case (fn)
      UDC_OUT_GE:     res = cur ? (cnt >= c1 - h) : (cnt >= c1);
      UDC_OUT_LE:     res = cur ? (cnt <= c1 + h) : (cnt <= c1);
      UDC_OUT_PULSE:  res = (cnt == c1) || pulse_active;
      UDC_OUT_WINDOW: res = (cnt >= c1) && (cnt <= c2);
      default:        res = 1'b0;
    endcase
    return res;
  endfunction

  // the window needs both values, so only the first output offers it
  udc_outfn_type fn2_eff;
  assign fn2_eff = (fn2 == UDC_OUT_WINDOW) ? UDC_OUT_NONE : fn2;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      out1_r <= 1'b0;
      out2_r <= 1'b0;
      pw1_r  <= '0;
      pw2_r  <= '0;
    end else begin
      out1_r <= out_next(fn1, out1_r, count_r, compare_value_one_r,
                         compare_value_two_r, hys_s, pw1_r != '0);
      out2_r <= out_next(fn2_eff, out2_r, count_r, compare_value_two_r,
                         compare_value_two_r, hys_s, pw2_r != '0);
      // pulse stretch counts down from the programmed duration
      if (fn1 == UDC_OUT_PULSE && count_r == compare_value_one_r) pw1_r <= pw_len;
      else if (pw1_r != '0) pw1_r <= pw1_r - 1'b1;
      if (fn2_eff == UDC_OUT_PULSE && count_r == compare_value_two_r) pw2_r <= pw_len;
      else if (pw2_r != '0) pw2_r <= pw2_r - 1'b1;
    end
  end
  assign first_output  = out1_r;
  assign second_output = out2_r;

  // ------------------------------------------------------------------
  // cycle snapshot
  // ------------------------------------------------------------------
  // status bits are live; the snapshot copies them at the sampling pulse
  logic [31:0] status_now;
  always_comb begin
    status_now = UDC_ZERO;
    status_now[UDC_ST_GATE]  = gate_int;
    status_now[UDC_ST_AUX]   = aux_prev_r;
    status_now[UDC_ST_OUT1]  = out1_r;
    status_now[UDC_ST_OUT2]  = out2_r;
    status_now[UDC_ST_DIRUP] = dir_up_r;
  end
  // the snapshot takes registered state, so a pulse in the sampling cycle shows next time
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      snap_count_r  <= $signed(UDC_ZERO);
      snap_latch_r  <= $signed(UDC_ZERO);
      snap_status_r <= UDC_ZERO;
    end else if (cycle_sample) begin
      snap_count_r  <= count_r;
      snap_latch_r  <= latch_r;
      snap_status_r <= status_now;
    end
  end

  // ------------------------------------------------------------------
  // read data
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      prdata_r <= UDC_RDZERO;
    end else if (rd_en) begin
      unique case (apb_req.paddr)
        UDC_OFS_CTRL:    prdata_r <= {31'h0000_0000, software_gate_bit_r};
        UDC_OFS_CFG:     prdata_r <= {25'h000_0000, cancel_r, aux_fn_r, dir_r, mode_r};
        UDC_OFS_HILIM:   prdata_r <= hi_limit_r;
        UDC_OFS_DIRECT:  prdata_r <= count_r;
        UDC_OFS_PREP:    prdata_r <= prepared_load_value_r;
        UDC_OFS_CMP1:    prdata_r <= compare_value_one_r;
        UDC_OFS_CMP2:    prdata_r <= compare_value_two_r;
        UDC_OFS_OUTPAR:  prdata_r <= output_behaviour_params_r;
        UDC_OFS_COUNT:   prdata_r <= count_r;
        UDC_OFS_LATCH:   prdata_r <= latch_r;
        UDC_OFS_STATUS:  prdata_r <= status_now;
        UDC_OFS_SNAPCNT: prdata_r <= snap_count_r;
        UDC_OFS_SNAPLAT: prdata_r <= snap_latch_r;
        UDC_OFS_SNAPSTS: prdata_r <= snap_status_r;
        default:         prdata_r <= UDC_RDZERO;
      endcase
    end
  end

  // unaligned or past the last register: error, nothing written
  logic unmapped;
  assign unmapped = (apb_req.paddr[1:0] != 2'b00) || (apb_req.paddr > UDC_OFS_SNAPSTS);
  // zero wait states: every access ends in its first access cycle
  always_comb begin
    apb_rsp.pready  = 1'b1;
    apb_rsp.pslverr = apb_req.psel && apb_req.penable && unmapped;
    apb_rsp.prdata  = prdata_r;
  end
endmodule

//--- src/udc_pkg.sv
// package for the up/down pulse counter core: register map, fields, enums
package udc_pkg;
  localparam logic [31:0] UDC_LIMIT_HI  = 32'h7FFF_FFFF;
  localparam logic [31:0] UDC_LIMIT_LO  = 32'h8000_0000;
  localparam logic [31:0] UDC_ZERO      = 32'h0000_0000;
  localparam logic [31:0] UDC_ONE       = 32'h0000_0001;
  localparam logic [31:0] UDC_RDZERO    = 32'h0000_0000;

  // ------------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------------
  localparam logic [7:0] UDC_OFS_CTRL    = 8'h00;
  localparam logic [7:0] UDC_OFS_CFG     = 8'h04;
  localparam logic [7:0] UDC_OFS_HILIM   = 8'h08;
  localparam logic [7:0] UDC_OFS_DIRECT  = 8'h0C;
  localparam logic [7:0] UDC_OFS_PREP    = 8'h10;
  localparam logic [7:0] UDC_OFS_CMP1    = 8'h14;
  localparam logic [7:0] UDC_OFS_CMP2    = 8'h18;
  localparam logic [7:0] UDC_OFS_OUTPAR  = 8'h1C;
  localparam logic [7:0] UDC_OFS_COUNT   = 8'h20;
  localparam logic [7:0] UDC_OFS_LATCH   = 8'h24;
  localparam logic [7:0] UDC_OFS_STATUS  = 8'h28;
  localparam logic [7:0] UDC_OFS_SNAPCNT = 8'h2C;
  localparam logic [7:0] UDC_OFS_SNAPLAT = 8'h30;
  localparam logic [7:0] UDC_OFS_SNAPSTS = 8'h34;

  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int UDC_CTRL_GATE   = 0;  // software_gate_bit
  localparam int UDC_CTRL_APPLY  = 1;  // write one: reassign parameters
  localparam int UDC_CFG_MODE_LO = 0;  // 2 bits
  localparam int UDC_CFG_DIR_LO  = 2;  // 2 bits
  localparam int UDC_CFG_AUX_LO  = 4;  // 2 bits
  localparam int UDC_CFG_CANCEL  = 6;  // canceling gate function
  localparam int UDC_OP_FN1_LO   = 0;  // 3 bits
  localparam int UDC_OP_FN2_LO   = 4;  // 3 bits
  localparam int UDC_OP_HYS_LO   = 8;  // 8 bits
  localparam int UDC_OP_PW_LO    = 16; // 16 bits
  localparam int UDC_ST_GATE     = 0;
  localparam int UDC_ST_AUX      = 1;
  localparam int UDC_ST_OUT1     = 2;
  localparam int UDC_ST_OUT2     = 3;
  localparam int UDC_ST_DIRUP    = 4;

  typedef enum logic [1:0] {
    UDC_MODE_CONT = 2'b00, UDC_MODE_ONCE = 2'b01, UDC_MODE_PERIOD = 2'b10
  } udc_mode_type;
  typedef enum logic [1:0] {
    UDC_DIR_NONE = 2'b00, UDC_DIR_UP = 2'b01, UDC_DIR_DOWN = 2'b10
  } udc_dir_type;
  typedef enum logic [1:0] {
    UDC_AUX_INPUT = 2'b00, UDC_AUX_GATE = 2'b01, UDC_AUX_LATCH = 2'b10, UDC_AUX_SYNC = 2'b11
  } udc_aux_type;
  typedef enum logic [2:0] {
    UDC_OUT_NONE = 3'b000, UDC_OUT_GE = 3'b001, UDC_OUT_LE = 3'b010,
    UDC_OUT_PULSE = 3'b011, UDC_OUT_WINDOW = 3'b100
  } udc_outfn_type;

  // encoder pulse side
  typedef struct packed {
    logic count_pulse;
    logic count_up;
  } udc_pulse_type;

  // APB slave signals
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } udc_apb_req_type;
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } udc_apb_rsp_type;
endpackage

//--- testbench/udc_core_properties.sv
// port-level properties of the up/down pulse counter core
`timescale 1ns/1ps
module udc_core_check
  import udc_pkg::*;
(
  // clock and reset
  input wire logic                     core_clk,
  input wire logic                     sys_rst,
  // watched ports
  input wire logic                     first_output,
  input wire logic                     second_output,
  input wire udc_pkg::udc_apb_req_type apb_req,
  input wire udc_pkg::udc_apb_rsp_type apb_rsp
);
  logic req_acc;
  logic bad_ad;
  assign req_acc = apb_req.psel && apb_req.penable;
  assign bad_ad = (apb_req.paddr > 8'h34) || (apb_req.paddr[1:0] != 2'b00);

  property p_ready_now;
    @(posedge core_clk) disable iff (sys_rst) req_acc |-> apb_rsp.pready;
  endproperty
  a_ready_now: assert property (p_ready_now) else $error("access not answered");
  property p_err_bad;
    @(posedge core_clk) disable iff (sys_rst) req_acc && bad_ad |-> apb_rsp.pslverr;
  endproperty
  a_err_bad: assert property (p_err_bad) else $error("unmapped access not refused");
  property p_err_good;
    @(posedge core_clk) disable iff (sys_rst) req_acc && !bad_ad |-> !apb_rsp.pslverr;
  endproperty
  a_err_good: assert property (p_err_good) else $error("mapped access refused");
  property p_err_idle;
    @(posedge core_clk) disable iff (sys_rst) !req_acc |-> !apb_rsp.pslverr;
  endproperty
  a_err_idle: assert property (p_err_idle) else $error("error outside access");
  property p_bad_zero;
    @(posedge core_clk) disable iff (sys_rst)
      req_acc && !apb_req.pwrite && bad_ad |-> apb_rsp.prdata == 32'h0000_0000;
  endproperty
  a_bad_zero: assert property (p_bad_zero) else $error("unmapped read not zero");
  property p_rdata_hold;
    @(posedge core_clk) disable iff (sys_rst)
      !$past(apb_req.psel && !apb_req.penable) && !$past(sys_rst) |-> $stable(apb_rsp.prdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  property p_rst_quiet;
    @(posedge core_clk) sys_rst |=> !first_output && !second_output;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("outputs on after reset");
  property p_rst_rdata;
    @(posedge core_clk) sys_rst |=> apb_rsp.prdata == 32'h0000_0000;
  endproperty
  a_rst_rdata: assert property (p_rst_rdata) else $error("read data not cleared");
endmodule

bind udc_core udc_core_check u_check (
  .core_clk(core_clk), .sys_rst(sys_rst), .first_output(first_output),
  .second_output(second_output), .apb_req(apb_req), .apb_rsp(apb_rsp)
);

//--- testbench/udc_core_test.sv
// self-checking bench for the up/down pulse counter core
`timescale 1ns/1ps
module udc_core_test;
  import udc_pkg::*;
  typedef struct packed {
    logic [31:0] cfg, hil, prep, dv;
    logic        dl, u;
    logic [7:0]  k;
    logic [31:0] x;
  } udc_row_type;
  logic            core_clk = 1'b0;
  logic            sys_rst = 1'b1;
  logic            aux_input = 1'b0;
  logic            cycle_sample = 1'b0;
  logic            go = 1'b0;
  logic            up = 1'b1;
  logic            slow = 1'b0;
  logic [7:0]      n = 8'h01;
  logic            busy;
  udc_pulse_type   pin;
  udc_apb_req_type req = '0;
  udc_apb_rsp_type rsp;
  logic [31:0]     q;
  logic            e;
  logic            o1, o2;
  int              miscompares = 0;
  int              compares = 0;
  logic [7:0]      ra [5] = '{UDC_OFS_PREP, UDC_OFS_CMP1, UDC_OFS_CMP2, UDC_OFS_COUNT, UDC_OFS_LATCH};
  udc_row_type     rows [7] = '{
    '{32'h40, 32'h0, 32'h0, 32'h7FFF_FFFF, 1'b1, 1'b1, 8'h01, 32'h8000_0000},
    '{32'h40, 32'h0, 32'h0, 32'h8000_0000, 1'b1, 1'b0, 8'h01, 32'h7FFF_FFFF},
    '{32'h46, 32'hA, 32'h3, 32'h0, 1'b0, 1'b1, 8'h0A, 32'h5},
    '{32'h45, 32'hA, 32'h3, 32'h0, 1'b0, 1'b1, 8'h0A, 32'h3},
    '{32'h4A, 32'hA, 32'h2, 32'h0, 1'b0, 1'b0, 8'h04, 32'h1},
    '{32'h42, 32'h0, 32'h9, 32'h7FFF_FFFF, 1'b1, 1'b1, 8'h01, 32'h9},
    '{32'h42, 32'h0, 32'h9, 32'h8000_0000, 1'b1, 1'b0, 8'h01, 32'h9}};

  always #50 core_clk = ~core_clk;

  udc_core u_dut (.core_clk(core_clk), .sys_rst(sys_rst), .pulse_in(pin),
    .aux_input(aux_input), .cycle_sample(cycle_sample), .first_output(o1),
    .second_output(o2), .apb_req(req), .apb_rsp(rsp));
  udc_pulse_model u_enc (.core_clk(core_clk), .sys_rst(sys_rst), .go(go), .up(up),
    .slow(slow), .n(n), .pulse_out(pin), .busy(busy));

  task conclude;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task chk(input string s, input logic [31:0] x, input logic [31:0] g);
    compares++;
    if (g !== x) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", s, x, g);
    end
  endtask

  // ----------------------------------------------------------------
  // bus and pulse drivers
  // ----------------------------------------------------------------
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge core_clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge core_clk);
    req.penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge core_clk);
      if (rsp.pready === 1'b1) break;
    end
    if (i == 16) begin
      miscompares++;
      conclude();
    end
    q = rsp.prdata;
    e = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] x, input string s);
    xfer(1'b0, a, 32'h0);
    chk(s, x, q);
  endtask

  task pulses(input logic [7:0] k, input logic u);
    int i;
    @(posedge core_clk);
    go <= 1'b1;
    n <= k;
    up <= u;
    @(posedge core_clk);
    go <= 1'b0;
    // wait on the falling edge so the model's own update has landed
    for (i = 0; i < 600; i++) begin
      @(negedge core_clk);
      if (busy === 1'b0) break;
    end
    if (i == 600) begin
      miscompares++;
      conclude();
    end
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    rd(UDC_OFS_COUNT, 32'h0, "count after reset");
    xfer(1'b0, 8'h38, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, q);
    wr(UDC_OFS_PREP, 32'h64);
    wr(UDC_OFS_DIRECT, 32'h5);
    rd(UDC_OFS_COUNT, 32'h5, "direct load");
    wr(UDC_OFS_CTRL, 32'h1);
    rd(UDC_OFS_COUNT, 32'h64, "gate start");
    pulses(8'h03, 1'b1);
    pulses(8'h01, 1'b0);
    rd(UDC_OFS_COUNT, 32'h66, "up and down");
    wr(UDC_OFS_CTRL, 32'h0);
    pulses(8'h02, 1'b1);
    rd(UDC_OFS_COUNT, 32'h66, "gate closed");
    wr(UDC_OFS_CTRL, 32'h1);
    pulses(8'h01, 1'b1);
    wr(UDC_OFS_CTRL, 32'h1);
    rd(UDC_OFS_COUNT, 32'h65, "no second start");
    wr(UDC_OFS_CFG, 32'h0);
    wr(UDC_OFS_CTRL, 32'h0);
    wr(UDC_OFS_CTRL, 32'h1);
    rd(UDC_OFS_COUNT, 32'h65, "resume keeps count");
    wr(UDC_OFS_CFG, 32'h60);
    wr(UDC_OFS_PREP, 32'h7);
    aux_input <= 1'b1;
    rd(UDC_OFS_LATCH, 32'h65, "latched count");
    rd(UDC_OFS_COUNT, 32'h7, "latch reload");
    aux_input <= 1'b0;
    wr(UDC_OFS_CFG, 32'h70);
    wr(UDC_OFS_PREP, 32'h9);
    aux_input <= 1'b1;
    rd(UDC_OFS_COUNT, 32'h9, "sync reload");
    cycle_sample <= 1'b1;
    @(posedge core_clk);
    cycle_sample <= 1'b0;
    pulses(8'h02, 1'b1);
    rd(UDC_OFS_SNAPCNT, 32'h9, "snapshot");
    rd(UDC_OFS_SNAPLAT, 32'h65, "snapshot latch");
    rd(UDC_OFS_COUNT, 32'hB, "live count");
    wr(UDC_OFS_CTRL, 32'h0);
    wr(UDC_OFS_CFG, 32'h48);
    wr(UDC_OFS_HILIM, 32'h55);
    wr(UDC_OFS_CTRL, 32'h2);
    foreach (ra[j]) rd(ra[j], 32'h55, "down reset state");
    wr(UDC_OFS_CFG, 32'h44);
    wr(UDC_OFS_CTRL, 32'h2);
    foreach (ra[j]) rd(ra[j], 32'h0, "up reset state");
    foreach (rows[r]) begin
      wr(UDC_OFS_CTRL, 32'h0);
      wr(UDC_OFS_CFG, rows[r].cfg);
      wr(UDC_OFS_HILIM, rows[r].hil);
      wr(UDC_OFS_CTRL, 32'h2);
      wr(UDC_OFS_PREP, rows[r].prep);
      wr(UDC_OFS_CTRL, 32'h1);
      if (rows[r].dl) wr(UDC_OFS_DIRECT, rows[r].dv);
      slow <= r[0];
      pulses(rows[r].k, rows[r].u);
      rd(UDC_OFS_COUNT, rows[r].x, "mode table");
    end
    wr(UDC_OFS_CFG, 32'h50);
    wr(UDC_OFS_PREP, 32'h20);
    aux_input <= 1'b0;
    pulses(8'h02, 1'b1);
    rd(UDC_OFS_COUNT, 32'h9, "hardware gate closed");
    aux_input <= 1'b1;
    wr(UDC_OFS_CMP1, 32'h22);
    wr(UDC_OFS_CMP2, 32'h22);
    wr(UDC_OFS_OUTPAR, 32'h221);
    rd(UDC_OFS_COUNT, 32'h20, "hardware gate start");
    pulses(8'h03, 1'b1);
    rd(UDC_OFS_COUNT, 32'h23, "compare count");
    chk("outputs", 32'h3, {30'h0, o1, o2});
    pulses(8'h02, 1'b1);
    rd(UDC_OFS_COUNT, 32'h25, "compare count");
    chk("outputs", 32'h2, {30'h0, o1, o2});
    pulses(8'h04, 1'b0);
    rd(UDC_OFS_COUNT, 32'h21, "compare count");
    chk("outputs", 32'h3, {30'h0, o1, o2});
    rd(UDC_OFS_STATUS, 32'hF, "status");
    conclude();
  end
endmodule

//--- testbench/udc_pulse_model.sv
// encoder-side pulse source for the up/down pulse counter bench
`timescale 1ns/1ps
module udc_pulse_model
  import udc_pkg::*;
(
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              sys_rst,
  // burst request
  input  wire logic              go,
  input  wire logic              up,
  input  wire logic              slow,
  input  wire logic [7:0]        n,
  // encoder side
  output udc_pkg::udc_pulse_type pulse_out,
  output logic                   busy
);
  logic [7:0] rem_r;
  logic       dir_r;
  logic       wait_r;
  assign busy = (rem_r != 8'h00);
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rem_r <= 8'h00;
      dir_r <= 1'b0;
      wait_r <= 1'b0;
      pulse_out <= '0;
    end else if (go) begin
      rem_r <= n;
      dir_r <= up;
      wait_r <= 1'b0;
      pulse_out.count_pulse <= 1'b0;
    end else if (busy && !wait_r) begin
      // direction travels with each step, nothing else steers it
      pulse_out <= '{count_pulse: 1'b1, count_up: dir_r};
      rem_r <= rem_r - 8'h01;
      wait_r <= slow;
    end else begin
      // direction line is not held between steps, so it toggles
      pulse_out <= '{count_pulse: 1'b0, count_up: ~pulse_out.count_up};
      wait_r <= 1'b0;
    end
  end
endmodule
